// ==== pwm_tcb.sv ====
// PWM channel secondary trigger, current-limit capture and blanking.
// Assumes timers and PWM outputs come from logic on CLK_SYS; fault and
// current-limit inputs are asynchronous pins.
`timescale 1ns/1ps
`include "pwm_tcb_params.svh"

// Overview of operation
// (RQ1) A 16-bit secondary compare value triggers the ADC when the secondary timer equals it.
// (RQ2) A match raises the interrupt only with trigger interrupt enable and dual trigger mode both set.
// (RQ3) One step of the compare value is one system clock period.
// (RQ4) Software uses zero, not the period value, to trigger at the period boundary.
// (RQ5) A current-limit leading edge latches the local PWM timer into the capture register.
// (RQ6) Current-limit edges during active blanking cause no capture when current-limit blanking is enabled.
// (RQ7) Enabled high-side rising and falling edges start or restart blanking.
// (RQ8) Enabled low-side rising and falling edges start or restart blanking.
// (RQ9) The fault input is blanked during the interval only when fault blanking is enabled.
// (RQ10) The current-limit input is blanked only when current-limit blanking is enabled.
// (RQ11) Software keeps both dead-time values at six or more while blanking is used.
// (RQ12) Unimplemented register bits read as zero.
// (RQ13) A retriggerable 12-bit counter on the system clock times the blanking interval.
// (RQ14) Dual trigger mode combines secondary with primary triggers for the ADC.
// (RQ15) All implemented register bits reset to zero.
// (RQ16) Blanked inputs read as inactive while the counter runs.
module pwm_tcb
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Timers, PWM outputs and primary trigger
   input wire logic [15:0] SECONDARY_TIMER,
   input wire logic [15:0] LOCAL_PWM_TIMER,
   input wire logic HIGH_SIDE_OUTPUT,
   input wire logic LOW_SIDE_OUTPUT,
   input wire logic PRIMARY_TRIGGER,
   // Protection inputs
   input wire logic FAULT_IN,
   input wire logic CURRENT_LIMIT_IN,
   // Results
   output logic ADC_TRIGGER,
   output logic SECONDARY_TRIGGER,
   output logic FAULT_OUT,
   output logic CURRENT_LIMIT_OUT,
   output logic BLANK_ACTIVE,
   output logic IRQ
);

   pwm_tcb_pkg::bus_req_type req;
   pwm_tcb_pkg::pwm_pair_type pwm_now;
   pwm_tcb_pkg::pwm_pair_type pwm_last_r;

   logic [15:0] secondary_compare_value_r;
   logic [15:0] captured_timer_value_r;
   logic [5:0] blank_ctrl_r;
   logic [11:0] blanking_delay_value_r;
   logic [1:0] ctrl_r;
   logic [`IRQ_WIDTH-1:0] irq_stat_r;
   logic [`IRQ_WIDTH-1:0] irq_mask_r;
   logic [`IRQ_WIDTH-1:0] irq_event;
   logic [`IRQ_WIDTH-1:0] irq_stat_nxt;
   logic [31:0] rdata_nxt;
   logic [1:0] pins_sync;
   logic cl_last_r;
   logic blank_on;

   // Field aliases
   wire high_rise_blank_trigger = blank_ctrl_r[5];
   wire high_fall_blank_trigger = blank_ctrl_r[4];
   wire low_rise_blank_trigger = blank_ctrl_r[3];
   wire low_fall_blank_trigger = blank_ctrl_r[2];
   wire fault_blanking_enable = blank_ctrl_r[1];
   wire current_limit_blanking_enable = blank_ctrl_r[0];
   wire trigger_interrupt_enable = ctrl_r[`BIT_TRIG_IE];
   wire dual_trigger_mode = ctrl_r[`BIT_DUAL_MODE];

   // Bus request bundle and address decode
   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   wire wr_strig = req.wr && req.addr == `OFS_STRIG;
   wire wr_cap = req.wr && req.addr == `OFS_CAP;
   wire wr_lebcon = req.wr && req.addr == `OFS_LEBCON;
   wire wr_lebdly = req.wr && req.addr == `OFS_LEBDLY;
   wire wr_ctrl = req.wr && req.addr == `OFS_CTRL;
   wire wr_stat = req.wr && req.addr == `OFS_IRQ_STAT;
   wire wr_mask = req.wr && req.addr == `OFS_IRQ_MASK;

   // Synchronise the asynchronous protection pins
   pin_sync #(.WIDTH(2)) u_sync
   (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .din({FAULT_IN, CURRENT_LIMIT_IN}),
      .dout(pins_sync)
   );
   wire fault_s = pins_sync[1];
   wire cl_s = pins_sync[0];

   // PWM edge detection and blanking retrigger selection
   assign pwm_now = '{high: HIGH_SIDE_OUTPUT, low: LOW_SIDE_OUTPUT};
   wire hr = high_rise_blank_trigger && pwm_now.high && !pwm_last_r.high; // see (RQ7)
   wire hf = high_fall_blank_trigger && !pwm_now.high && pwm_last_r.high; // see (RQ7)
   wire lr = low_rise_blank_trigger && pwm_now.low && !pwm_last_r.low; // see (RQ8)
   wire lf = low_fall_blank_trigger && !pwm_now.low && pwm_last_r.low; // see (RQ8)
   wire retrigger = hr || hf || lr || lf;

   // Blanking interval timer on the system clock
   blank_counter u_blank
   (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .retrigger(retrigger), // see (RQ13)
      .delay(blanking_delay_value_r),
      .active(blank_on)
   );

   // Blanked views of the protection inputs
   wire fault_q = fault_s && !(fault_blanking_enable && blank_on); // see (RQ9) (RQ16)
   wire cl_q = cl_s && !(current_limit_blanking_enable && blank_on); // see (RQ10) (RQ16)
   wire cl_edge = cl_q && !cl_last_r; // see (RQ5) (RQ6)

   // Secondary compare, one step per clock since the timer counts SYSCLK
   wire strig_match = SECONDARY_TIMER == secondary_compare_value_r; // see (RQ1) (RQ3)
   wire adc_nxt = PRIMARY_TRIGGER || (dual_trigger_mode && strig_match); // see (RQ14)
   wire trig_irq_event = strig_match && trigger_interrupt_enable && dual_trigger_mode; // see (RQ2)

   // Interrupt status: hardware set wins over write-one clear
   assign irq_event = {cl_edge, trig_irq_event};
   assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? WDATA[`IRQ_WIDTH-1:0] : '0)) | irq_event;

   // Read multiplexer, upper bits zero
   assign rdata_nxt = !req.rd ? 32'h0000_0000 :
      req.addr == `OFS_STRIG ? {16'h0000, secondary_compare_value_r} :
      req.addr == `OFS_CAP ? {16'h0000, captured_timer_value_r} :
      req.addr == `OFS_LEBCON ? {16'h0000, blank_ctrl_r, 10'h000} : // see (RQ12)
      req.addr == `OFS_LEBDLY ? {20'h00000, blanking_delay_value_r} :
      req.addr == `OFS_CTRL ? {30'h0000_0000, ctrl_r} :
      req.addr == `OFS_IRQ_STAT ? {30'h0000_0000, irq_stat_r} :
      req.addr == `OFS_IRQ_MASK ? {30'h0000_0000, irq_mask_r} :
      32'h0000_0000;

   // Software-written registers
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         secondary_compare_value_r <= `RST_WORD16; // see (RQ15)
         blank_ctrl_r <= 6'h00;
         blanking_delay_value_r <= `RST_DELAY12;
         ctrl_r <= 2'h0;
         irq_mask_r <= '0;
      end
      else
      begin
         if (wr_strig)
            secondary_compare_value_r <= WDATA[15:0];
         if (wr_lebcon)
            blank_ctrl_r <= WDATA[`BIT_HIGH_RISE:`BIT_CL_BLANK];
         if (wr_lebdly)
            blanking_delay_value_r <= WDATA[11:0];
         if (wr_ctrl)
            ctrl_r <= WDATA[1:0];
         if (wr_mask)
            irq_mask_r <= WDATA[`IRQ_WIDTH-1:0];
      end
   end

   // Capture register: edge capture wins, low byte writable
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         captured_timer_value_r <= `RST_WORD16;
      else if (cl_edge)
         captured_timer_value_r <= LOCAL_PWM_TIMER; // see (RQ5)
      else if (wr_cap)
         captured_timer_value_r[7:0] <= WDATA[7:0];
   end

   // Edge history, status and registered outputs
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pwm_last_r <= '0;
         cl_last_r <= 1'b0;
         irq_stat_r <= '0;
         RDATA <= 32'h0000_0000;
         ADC_TRIGGER <= 1'b0;
         SECONDARY_TRIGGER <= 1'b0;
         FAULT_OUT <= 1'b0;
         CURRENT_LIMIT_OUT <= 1'b0;
         BLANK_ACTIVE <= 1'b0;
         IRQ <= 1'b0;
      end
      else
      begin
         pwm_last_r <= pwm_now;
         cl_last_r <= cl_q;
         irq_stat_r <= irq_stat_nxt;
         RDATA <= rdata_nxt;
         ADC_TRIGGER <= adc_nxt;
         SECONDARY_TRIGGER <= strig_match; // see (RQ1)
         FAULT_OUT <= fault_q;
         CURRENT_LIMIT_OUT <= cl_q;
         BLANK_ACTIVE <= blank_on;
         IRQ <= |(irq_stat_nxt & irq_mask_r);
      end
   end

endmodule : pwm_tcb

// ==== pwm_tcb_params.svh ====
// Constants for the PWM trigger, capture and blanking channel.
// Assumes inclusion by its bare name from the modules.
`ifndef PWM_TCB_PARAMS_SVH
`define PWM_TCB_PARAMS_SVH

// Register offsets (byte addresses)
`define OFS_STRIG 8'h00
`define OFS_CAP 8'h04
`define OFS_LEBCON 8'h08
`define OFS_LEBDLY 8'h0c
`define OFS_CTRL 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18

// Blanking control field positions
`define BIT_HIGH_RISE 15
`define BIT_HIGH_FALL 14
`define BIT_LOW_RISE 13
`define BIT_LOW_FALL 12
`define BIT_FLT_BLANK 11
`define BIT_CL_BLANK 10

// Control register field positions
`define BIT_TRIG_IE 0
`define BIT_DUAL_MODE 1

// Interrupt status bit positions
`define IRQ_TRIG 0
`define IRQ_CAPTURE 1
`define IRQ_WIDTH 2

// Reset values
`define RST_WORD16 16'h0000
`define RST_DELAY12 12'h000

// Clock period, ns, and cycles per compare step
`define SYSCLK_PERIOD_NS 5
`define COMPARE_STEP_NS 5
`define COMPARE_STEP_CYCLES (`COMPARE_STEP_NS / `SYSCLK_PERIOD_NS)

`endif

// ==== pwm_tcb_pkg.sv ====
// Types for the PWM trigger, capture and blanking channel.
// Assumes the params header sits in the same folder.
package pwm_tcb_pkg;

   // Register bus request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   // PWM output pair
   typedef struct packed
   {
      logic high;
      logic low;
   } pwm_pair_type;

   // Blanking counter states
   typedef enum logic [0:0]
   {
      BLANK_IDLE = 1'b0,
      BLANK_RUN = 1'b1
   } blank_state_type;

endpackage : pwm_tcb_pkg

// ==== pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes inputs are levels that change slowly relative to CLK_SYS.
`timescale 1ns/1ps
module pin_sync #(parameter int WIDTH = 2)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pins
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= '0;
         dout <= '0;
      end
      else
      begin
         meta_r <= din;
         dout <= meta_r;
      end
   end

endmodule : pin_sync

// ==== blank_counter.sv ====
// Retriggerable leading-edge blanking counter.
// Assumes retrigger is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
`include "pwm_tcb_params.svh"
module blank_counter
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic retrigger,
   input wire logic [11:0] delay,
   // Status
   output logic active
);

   pwm_tcb_pkg::blank_state_type state_r;
   pwm_tcb_pkg::blank_state_type state_nxt;
   logic [11:0] count_r;
   logic [11:0] count_nxt;

   // Reload on retrigger, count down to zero otherwise
   always_comb
   begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         pwm_tcb_pkg::BLANK_IDLE:
         begin
            if (retrigger && delay != `RST_DELAY12)
            begin
               state_nxt = pwm_tcb_pkg::BLANK_RUN;
               count_nxt = delay;
            end
         end
         pwm_tcb_pkg::BLANK_RUN:
         begin
            if (retrigger)
               count_nxt = delay; // see (RQ13)
            else if (count_r == 12'h001)
            begin
               state_nxt = pwm_tcb_pkg::BLANK_IDLE;
               count_nxt = `RST_DELAY12;
            end
            else
               count_nxt = count_r - 12'h001;
            if (retrigger && delay == `RST_DELAY12)
               state_nxt = pwm_tcb_pkg::BLANK_IDLE;
         end
         default:
         begin
            state_nxt = pwm_tcb_pkg::BLANK_IDLE;
            count_nxt = `RST_DELAY12;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= pwm_tcb_pkg::BLANK_IDLE;
         count_r <= `RST_DELAY12;
      end
      else
      begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   assign active = (state_r == pwm_tcb_pkg::BLANK_RUN);

endmodule : blank_counter

// ==== pwm_tcb_monitor.sv ====
// Checker for the trigger, capture and blanking channel.
// Assumes a bind to pwm_tcb; registers are mirrored from bus writes.
`timescale 1ns/1ps
module pwm_tcb_monitor
(
   // Clock, reset and register port
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // Timer, PWM and trigger inputs
   input wire logic [15:0] SECONDARY_TIMER,
   input wire logic HIGH_SIDE_OUTPUT,
   input wire logic PRIMARY_TRIGGER,
   // Results
   input wire logic ADC_TRIGGER,
   input wire logic SECONDARY_TRIGGER,
   input wire logic FAULT_OUT,
   input wire logic CURRENT_LIMIT_OUT,
   input wire logic BLANK_ACTIVE,
   input wire logic IRQ
);
   logic [15:0] cmp_r;
   logic [15:0] leb_r;
   logic [11:0] dly_r;
   logic [1:0] ctl_r;
   logic [1:0] msk_r;
   logic [1:0] live_r;
   // Mirror of the compare, blanking control, delay, control and mask registers
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cmp_r <= 16'h0000;
         leb_r <= 16'h0000;
         dly_r <= 12'h000;
         ctl_r <= 2'h0;
         msk_r <= 2'h0;
         live_r <= 2'h0;
      end
      else
      begin
         live_r <= {live_r[0], 1'b1};
         if (WR && ADDR == 8'h00) cmp_r <= WDATA[15:0];
         if (WR && ADDR == 8'h08) leb_r <= WDATA[15:0];
         if (WR && ADDR == 8'h0c) dly_r <= WDATA[11:0];
         if (WR && ADDR == 8'h10) ctl_r <= WDATA[1:0];
         if (WR && ADDR == 8'h18) msk_r <= WDATA[1:0];
      end
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   // Enabled high side rise, then blanking two cycles on
   sequence high_rise_seen;
      $rose(HIGH_SIDE_OUTPUT) && leb_r[15] && dly_r != 12'h000;
   endsequence
   sequence blank_follows;
      ##2 BLANK_ACTIVE;
   endsequence
   a_blank_start: assert property
      (high_rise_seen |-> blank_follows) else $error("no blanking");
   a_strig_match: assert property
      (live_r[1] |-> SECONDARY_TRIGGER == $past(SECONDARY_TIMER == cmp_r))
      else $error("secondary trigger wrong");
   a_adc_combine: assert property
      (live_r[1] |-> ADC_TRIGGER == ($past(PRIMARY_TRIGGER) ||
         ($past(ctl_r[1]) && SECONDARY_TRIGGER))) else $error("adc wrong");
   a_trig_irq: assert property
      (live_r[1] && $past(ctl_r) == 2'h3 && $past(msk_r[0]) &&
         SECONDARY_TRIGGER |-> IRQ) else $error("irq missing");
   a_irq_masked: assert property
      (msk_r == 2'h0 && $past(msk_r) == 2'h0 |-> !IRQ)
      else $error("masked irq seen");
   a_rdata_idle: assert property
      (!$past(RD) |-> RDATA == 32'h0) else $error("stray read data");
   a_upper_zero: assert property
      (RDATA[31:16] == 16'h0000) else $error("upper bits set");
   a_leb_low: assert property
      ($past(RD && ADDR == 8'h08) |-> RDATA[9:0] == 10'h000)
      else $error("low blanking bits set");
   a_fault_blank: assert property
      (BLANK_ACTIVE && $past(BLANK_ACTIVE) && leb_r[11] && $past(leb_r[11])
         |-> !FAULT_OUT) else $error("fault not blanked");
   a_cl_blank: assert property
      (BLANK_ACTIVE && $past(BLANK_ACTIVE) && leb_r[10] && $past(leb_r[10])
         |-> !CURRENT_LIMIT_OUT) else $error("limit not blanked");
endmodule : pwm_tcb_monitor

bind pwm_tcb pwm_tcb_monitor pwm_tcb_monitor_inst
(
   .CLK_SYS, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .SECONDARY_TIMER,
   .HIGH_SIDE_OUTPUT, .PRIMARY_TRIGGER, .ADC_TRIGGER, .SECONDARY_TRIGGER,
   .FAULT_OUT, .CURRENT_LIMIT_OUT, .BLANK_ACTIVE, .IRQ
);

// ==== pwm_tcb_partner.sv ====
// Protection pin sources and ADC trigger sink.
// Assumes requests from the bench change at the rising edge of clk.
`timescale 1ns/1ps
module pwm_tcb_partner
(
   // Clock and requests
   input wire logic clk,
   input wire logic fault_req,
   input wire logic cl_req,
   input wire logic adc_trigger,
   // Pins and trigger count
   output logic fault_pin = 1'b0,
   output logic cl_pin = 1'b0,
   output int adc_count = 0
);
   // Pins move off the edge, as asynchronous sources do
   always @(posedge clk)
   begin
      fault_pin <= #2 fault_req;
      cl_pin <= #2 cl_req;
      if (adc_trigger === 1'b1) adc_count <= adc_count + 1;
   end
endmodule : pwm_tcb_partner

// ==== pwm_tcb_bench.sv ====
// Self-checking bench for the trigger, capture and blanking channel.
// Assumes design, checker and partner files are compiled before it.
`timescale 1ns/1ps
module pwm_tcb_bench;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hi = 1'b0;
   logic lo = 1'b0, prim = 1'b0, freq = 1'b0, creq = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] stmr = 16'hffff, ltmr = 16'h0000;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic fpin, cpin, adc, strg, fout, clout, bact, irq;
   int seed = 56751, miscompares = 0, checked = 0;
   int bsum = 0, fsum = 0, csum = 0, adc_count, n, m, i, j;
   pwm_tcb pwm_tcb_inst (.CLK_SYS(clk), .RESET_N(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SECONDARY_TIMER(stmr), .LOCAL_PWM_TIMER(ltmr),
      .HIGH_SIDE_OUTPUT(hi), .LOW_SIDE_OUTPUT(lo), .PRIMARY_TRIGGER(prim),
      .FAULT_IN(fpin), .CURRENT_LIMIT_IN(cpin), .ADC_TRIGGER(adc),
      .SECONDARY_TRIGGER(strg), .FAULT_OUT(fout),
      .CURRENT_LIMIT_OUT(clout), .BLANK_ACTIVE(bact), .IRQ(irq));
   pwm_tcb_partner pwm_tcb_partner_inst (.clk(clk), .fault_req(freq),
      .cl_req(creq), .adc_trigger(adc), .fault_pin(fpin), .cl_pin(cpin),
      .adc_count(adc_count));
   // Clock and high-cycle tallies
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      bsum <= bsum + bact;
      fsum <= fsum + fout;
      csum <= csum + clout;
   end
   // Readable bits of each place after a write
   function logic [31:0] impl(input logic [7:0] a);
      case (a)
         8'h00: return 32'h0000ffff;
         8'h04: return 32'h000000ff;
         8'h08: return 32'h0000fc00;
         8'h0c: return 32'h00000fff;
         8'h10, 8'h18: return 32'h00000003;
         default: return 32'h0;
      endcase
   endfunction : impl
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : check
   task end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr32
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask : rchk
   initial
   begin
      #100000 miscompares++;
      end_sim;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 32; i += 4) rchk(8'(i), 32'h0);
      for (i = 0; i < 32; i += 4)
      begin
         v = $random(seed);
         wr32(8'(i), v);
         rchk(8'(i), v & impl(8'(i)));
         wr32(8'(i), 32'h0);
      end
      $display("register test done");
      // Match at zero for the period boundary, then at random values
      for (i = 0; i < 4; i++)
      begin
         v = (i == 0) ? 32'h0 : $random(seed);
         wr32(8'h00, v);
         wr32(8'h10, 32'(i));
         wr32(8'h18, 32'h1);
         n = adc_count;
         @(posedge clk);
         stmr <= v[15:0];
         @(posedge clk);
         stmr <= ~v[15:0];
         #1 check(strg, 32'h1);
         check(adc, 32'(i / 2));
         check(irq, 32'(i == 3));
         @(posedge clk);
         #1 check(strg, 32'h0);
         check(adc_count - n, 32'(i / 2));
         rchk(8'h14, 32'(i == 3));
         wr32(8'h18, 32'h0);
         wr32(8'h14, 32'h1);
         #1 check(irq, 32'h0);
      end
      // Primary trigger alone reaches the ADC trigger for one cycle
      n = adc_count;
      @(posedge clk);
      prim <= 1'b1;
      @(posedge clk);
      prim <= 1'b0;
      #1 check(adc, 32'h1);
      @(posedge clk);
      #1 check(adc, 32'h0);
      check(adc_count - n, 32'h1);
      $display("trigger test done");
      // Dead time is set outside this block at six or more
      wr32(8'h0c, 32'h4);
      for (i = 0; i < 4; i++)
      begin
         wr32(8'h08, 32'h8000 >> i);
         n = bsum;
         for (j = 0; j < 4; j++)
         begin
            @(posedge clk);
            if (j < 2) hi <= ~hi;
            else lo <= ~lo;
            repeat (10) @(posedge clk);
         end
         check(bsum - n, 32'h4);
      end
      wr32(8'h08, 32'hc000);
      n = bsum;
      hi <= 1'b1;
      repeat (2) @(posedge clk);
      hi <= 1'b0;
      repeat (12) @(posedge clk);
      check(bsum - n, 32'h6);
      $display("blanking test done");
      wr32(8'h0c, 32'd30);
      for (i = 0; i < 2; i++)
      begin
         wr32(8'h08, 32'h8000 | (i == 1 ? 32'h0c00 : 32'h0));
         n = fsum;
         m = csum;
         @(posedge clk);
         hi <= 1'b1;
         repeat (6) @(posedge clk);
         freq <= 1'b1;
         creq <= 1'b1;
         repeat (6) @(posedge clk);
         freq <= 1'b0;
         creq <= 1'b0;
         hi <= 1'b0;
         repeat (40) @(posedge clk);
         check(fsum == n, 32'(i));
         check(csum == m, 32'(i));
         rchk(8'h14, i == 1 ? 32'h0 : 32'h2);
         wr32(8'h14, 32'h3);
      end
      v = $random(seed);
      wr32(8'h08, 32'h0);
      ltmr <= v[15:0];
      creq <= 1'b1;
      repeat (8) @(posedge clk);
      ltmr <= ~v[15:0];
      creq <= 1'b0;
      rchk(8'h04, {16'h0, v[15:0]});
      $display("capture test done");
      end_sim;
   end
endmodule : pwm_tcb_bench
